// ==== design/ett_pkg.sv ====
// constants and register map of the eight-bit capture/compare timer
//
// Contract
// - capture one flag on pin edge or period
// - capture one flag cleared by status read, access
// - compare one flag on match, same clearing
// - overflow flag on wrap, cleared via counter
// - shadow counter access never clears overflow
// - capture two flag on pin two edge
// - compare two flag on match, same clearing
// - disable bit freezes prescaler, counter, compare output levels; compare output enables drop low
// - registers stay accessible while disabled
// - status read-only except disable; low bits zero
// - capture one copies counter on event
// - capture two copies counter on event
// - two compare registers, reset zero, always compared
// - counter resets to FCh, both views show it
// - any counter register write resets counter
// - registers at consecutive indices 3C to 44
// - clock select picks prescaler divide
// - shared interrupt from flags and enables
// - pulse-width mode restarts at compare two
package ett_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CTL_TWO = 8'h3C;
  localparam logic [7:0] IDX_CTL_ONE = 8'h3D;
  localparam logic [7:0] IDX_STATUS = 8'h3E;
  localparam logic [7:0] IDX_CAP_ONE = 8'h3F;
  localparam logic [7:0] IDX_CMP_ONE = 8'h40;
  localparam logic [7:0] IDX_COUNTER = 8'h41;
  localparam logic [7:0] IDX_SHADOW = 8'h42;
  localparam logic [7:0] IDX_CAP_TWO = 8'h43;
  localparam logic [7:0] IDX_CMP_TWO = 8'h44;
  // control two fields
  localparam int C2_PIN1_EN = 7;
  localparam int C2_PIN2_EN = 6;
  localparam int C2_PULSE = 5;
  localparam int C2_PWM = 4;
  localparam int C2_CLK_HI = 3;
  localparam int C2_CLK_LO = 2;
  localparam int C2_EDGE2 = 1;
  localparam logic [7:0] C2_WMASK = 8'hFE;
  // control one fields
  localparam int C1_CAP_IE = 7;
  localparam int C1_CMP_IE = 6;
  localparam int C1_OVF_IE = 5;
  localparam int C1_FORCE2 = 4;
  localparam int C1_FORCE1 = 3;
  localparam int C1_LEVEL2 = 2;
  localparam int C1_EDGE1 = 1;
  localparam int C1_LEVEL1 = 0;
  // status fields; flags sit at bits 7..3 in order below
  localparam int ST_DISABLE = 2;
  localparam int ST_FLAG_LSB = 3;
  localparam int NFLAG = 5;
  localparam int F_CAP1 = 4;
  localparam int F_CMP1 = 3;
  localparam int F_OVF = 2;
  localparam int F_CAP2 = 1;
  localparam int F_CMP2 = 0;
  // reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'hFC;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  // clock select codes
  localparam logic [1:0] CS_DIV4 = 2'h0;
  localparam logic [1:0] CS_DIV2 = 2'h1;
  localparam logic [1:0] CS_DIV8 = 2'h2;
  localparam logic [1:0] CS_SLOW = 2'h3;
  localparam int DIV_TWO = 2;
  localparam int DIV_FOUR = 4;
  localparam int DIV_EIGHT = 8;
  localparam int SLOW_DIV = 8000;

  // register whose access clears a given flag
  function automatic logic [7:0] ett_clear_idx(input int f);
    case (f)
      F_CAP1: ett_clear_idx = IDX_CAP_ONE;
      F_CMP1: ett_clear_idx = IDX_CMP_ONE;
      F_OVF: ett_clear_idx = IDX_COUNTER;
      F_CAP2: ett_clear_idx = IDX_CAP_TWO;
      default: ett_clear_idx = IDX_CMP_TWO;
    endcase
  endfunction
endpackage

// ==== design/ett_prescaler.sv ====
// prescaler producing the counter tick
`timescale 1ns/1ns
`default_nettype none
module ett_prescaler import ett_pkg::*; #(
  parameter int SLOW_DIVIDE = SLOW_DIV
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic [1:0] clock_select,
  // tick out
  output logic tick
);
  initial begin
    if (SLOW_DIVIDE < DIV_EIGHT || SLOW_DIVIDE > 16'hFFFF) begin
      $error("slow divide out of range");
    end
  end
  logic [15:0] div_reg;
  logic [15:0] limit;
  logic [15:0] div_next;
  always_comb begin
    unique case (clock_select)
      CS_DIV4: limit = 16'(DIV_FOUR - 1);
      CS_DIV2: limit = 16'(DIV_TWO - 1);
      CS_DIV8: limit = 16'(DIV_EIGHT - 1);
      CS_SLOW: limit = 16'(SLOW_DIVIDE - 1);
    endcase
    tick = run && (div_reg >= limit);
    div_next = tick ? 16'h0000 : div_reg + 16'h0001;
  end
  // frozen while not running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 16'h0000;
    end else if (run) begin
      div_reg <= div_next;
    end
  end
endmodule
`default_nettype wire

// ==== design/ett_edge.sv ====
// selectable edge detector for a capture input
`timescale 1ns/1ns
`default_nettype none
module ett_edge (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and edge choice, 1 selects rising
  input wire logic pin,
  input wire logic rising,
  // one-cycle event
  output logic event_pulse
);
  logic last_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= pin;
    end
  end
  assign event_pulse = rising ? (pin && !last_reg) : (!pin && last_reg);
endmodule
`default_nettype wire

// ==== design/ett_timer.sv ====
// eight-bit capture/compare timer with apb register access
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module ett_timer import ett_pkg::*; #(
  parameter int SLOW_DIVIDE = SLOW_DIV
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // capture inputs
  input wire logic capture_one_pin,
  input wire logic capture_two_pin,
  // compare outputs
  output logic compare_one_pin,
  output logic compare_one_oe,
  output logic compare_two_pin,
  output logic compare_two_oe,
  // shared interrupt
  output logic timer_irq
);
  initial begin
    if (SLOW_DIVIDE < DIV_EIGHT) begin
      $error("slow divide too small");
    end
  end

  // registers
  logic [7:0] control_two_reg;
  logic [7:0] control_one_reg;
  logic timer_disable_reg;
  logic [NFLAG-1:0] flag_reg;
  logic [NFLAG-1:0] arm_reg;
  logic [7:0] capture_one_value_reg;
  logic [7:0] capture_two_value_reg;
  logic [7:0] compare_one_value_reg;
  logic [7:0] compare_two_value_reg;
  logic [7:0] counter_reg;
  logic moved_reg;
  logic pin1_reg;
  logic pin2_reg;
  logic [31:0] rdata_reg;

  // bus decode
  logic [7:0] idx;
  logic mapped;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic [7:0] timer_status;

  assign idx = paddr[9:2];
  assign mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                  (idx >= IDX_CTL_TWO) && (idx <= IDX_CMP_TWO);
  assign setup = psel && !penable;
  assign access = psel && penable && mapped;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = rdata_reg;

  // status view, low two bits read zero
  assign timer_status = {flag_reg, timer_disable_reg, 2'h0};

  // derived controls
  logic pwm_mode;
  logic run;
  logic tick;
  assign pwm_mode = control_two_reg[C2_PWM];
  assign run = !timer_disable_reg;

  ett_prescaler #(
    .SLOW_DIVIDE(SLOW_DIVIDE)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .clock_select(control_two_reg[C2_CLK_HI:C2_CLK_LO]),
    .tick(tick)
  );

  // capture edge detectors
  logic cap1_edge;
  logic cap2_edge;
  ett_edge u_edge_one (
    .pclk(pclk),
    .presetn(presetn),
    .pin(capture_one_pin),
    .rising(control_one_reg[C1_EDGE1]),
    .event_pulse(cap1_edge)
  );
  ett_edge u_edge_two (
    .pclk(pclk),
    .presetn(presetn),
    .pin(capture_two_pin),
    .rising(control_two_reg[C2_EDGE2]),
    .event_pulse(cap2_edge)
  );

  // read data captured in the setup phase
  logic [7:0] rd_byte;
  always_comb begin
    unique case (idx)
      IDX_CTL_TWO: rd_byte = control_two_reg & C2_WMASK;
      IDX_CTL_ONE: rd_byte = control_one_reg;
      IDX_STATUS: rd_byte = timer_status;
      IDX_CAP_ONE: rd_byte = capture_one_value_reg;
      IDX_CMP_ONE: rd_byte = compare_one_value_reg;
      IDX_COUNTER: rd_byte = counter_reg;
      IDX_SHADOW: rd_byte = counter_reg;
      IDX_CAP_TWO: rd_byte = capture_two_value_reg;
      IDX_CMP_TWO: rd_byte = compare_two_value_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      rdata_reg <= mapped && !pwrite ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // control writes, allowed whether or not the timer runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_two_reg <= CTL_RST;
      control_one_reg <= CTL_RST;
      timer_disable_reg <= 1'b0;
    end else if (wr) begin
      if (idx == IDX_CTL_TWO) begin
        control_two_reg <= pwdata[7:0] & C2_WMASK;
      end
      if (idx == IDX_CTL_ONE) begin
        control_one_reg <= pwdata[7:0];
      end
      if (idx == IDX_STATUS) begin
        timer_disable_reg <= pwdata[ST_DISABLE];
      end
    end
  end

  // compare registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_one_value_reg <= CMP_RST;
      compare_two_value_reg <= CMP_RST;
    end else if (wr) begin
      if (idx == IDX_CMP_ONE) begin
        compare_one_value_reg <= pwdata[7:0];
      end
      if (idx == IDX_CMP_TWO) begin
        compare_two_value_reg <= pwdata[7:0];
      end
    end
  end

  // counter
  logic cnt_wr;
  logic period_end;
  assign cnt_wr = wr && (idx == IDX_COUNTER || idx == IDX_SHADOW);
  assign period_end = tick && pwm_mode && (counter_reg == compare_two_value_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_reg <= CNT_RST;
    end else if (cnt_wr) begin
      counter_reg <= CNT_RST;
    end else if (period_end) begin
      counter_reg <= CNT_ZERO;
    end else if (tick) begin
      counter_reg <= counter_reg + 8'h01;
    end
  end

  // marks a counter value freshly reached, so a match fires once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      moved_reg <= 1'b0;
    end else begin
      moved_reg <= tick && !cnt_wr;
    end
  end

  // events
  logic match1;
  logic match2;
  logic wrap;
  logic cap1_evt;
  logic cap2_evt;
  logic [NFLAG-1:0] set_vec;
  assign match1 = moved_reg && (counter_reg == compare_one_value_reg);
  assign match2 = moved_reg && (counter_reg == compare_two_value_reg);
  assign wrap = tick && !period_end && (counter_reg == CNT_MAX);
  assign cap1_evt = cap1_edge && !pwm_mode;
  assign cap2_evt = cap2_edge;

  always_comb begin
    set_vec = '0;
    set_vec[F_CAP1] = cap1_evt || period_end;
    set_vec[F_CMP1] = match1 && !pwm_mode;
    set_vec[F_OVF] = wrap;
    set_vec[F_CAP2] = cap2_evt;
    set_vec[F_CMP2] = match2 && !pwm_mode;
  end

  // capture values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_one_value_reg <= 8'h00;
      capture_two_value_reg <= 8'h00;
    end else begin
      if (cap1_evt) begin
        capture_one_value_reg <= counter_reg;
      end
      if (cap2_evt) begin
        capture_two_value_reg <= counter_reg;
      end
    end
  end

  // flag clear: armed by status read, fired by matching access
  logic [NFLAG-1:0] clr_vec;
  always_comb begin
    clr_vec = '0;
    for (int f = 0; f < NFLAG; f++) begin
      clr_vec[f] = arm_reg[f] && access && (idx == ett_clear_idx(f));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_reg <= '0;
    end else begin
      for (int f = 0; f < NFLAG; f++) begin
        if (rd && idx == IDX_STATUS && rdata_reg[ST_FLAG_LSB + f]) begin
          arm_reg[f] <= 1'b1;
        end else if (clr_vec[f]) begin
          arm_reg[f] <= 1'b0;
        end
      end
    end
  end

  // set beats clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= '0;
    end else begin
      for (int f = 0; f < NFLAG; f++) begin
        if (set_vec[f]) begin
          flag_reg[f] <= 1'b1;
        end else if (clr_vec[f]) begin
          flag_reg[f] <= 1'b0;
        end
      end
    end
  end

  // compare output levels, held while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin1_reg <= 1'b0;
    end else if (run) begin
      if (control_one_reg[C1_FORCE1]) begin
        pin1_reg <= control_one_reg[C1_LEVEL1];
      end else if (pwm_mode && period_end) begin
        pin1_reg <= control_one_reg[C1_LEVEL2];
      end else if (match1) begin
        pin1_reg <= control_one_reg[C1_LEVEL1];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin2_reg <= 1'b0;
    end else if (run) begin
      if (control_one_reg[C1_FORCE2]) begin
        pin2_reg <= control_one_reg[C1_LEVEL2];
      end else if (match2 && !pwm_mode) begin
        pin2_reg <= control_one_reg[C1_LEVEL2];
      end
    end
  end

  assign compare_one_pin = pin1_reg;
  assign compare_two_pin = pin2_reg;
  assign compare_one_oe = control_two_reg[C2_PIN1_EN] && run;
  assign compare_two_oe = control_two_reg[C2_PIN2_EN] && run;

  // shared interrupt
  assign timer_irq =
    (control_one_reg[C1_CAP_IE] && (flag_reg[F_CAP1] || flag_reg[F_CAP2])) ||
    (control_one_reg[C1_CMP_IE] && (flag_reg[F_CMP1] || flag_reg[F_CMP2])) ||
    (control_one_reg[C1_OVF_IE] && flag_reg[F_OVF]);
endmodule
`default_nettype wire

// ==== dv/ett_timer_sva.sv ====
// assertions on the timer's apb and pin ports
`timescale 1ns/1ns
`default_nettype none
module ett_timer_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic capture_one_pin,
  input wire logic capture_two_pin,
  input wire logic compare_one_pin,
  input wire logic compare_one_oe,
  input wire logic compare_two_pin,
  input wire logic compare_two_oe,
  input wire logic timer_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, rd, inmap, dis, cw;
  logic [2:0] ie;
  assign acc = psel && penable;
  assign rd = acc && !pwrite;
  assign inmap = paddr[9:2] >= 8'h3C && paddr[9:2] <= 8'h44;
  // track disable bit, irq enables and counter reloads made while frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis <= 1'b0;
      ie <= 3'h0;
      cw <= 1'b0;
    end else begin
      if (acc && pwrite && paddr == 12'h0F8) dis <= pwdata[2];
      if (acc && pwrite && paddr == 12'h0F4) ie <= pwdata[7:5];
      cw <= dis && (cw || (acc && pwrite && (paddr == 12'h104 || paddr == 12'h108)));
    end
  end
  ready_zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("pready low in access phase");
  unmapped_err_a: assert property (acc && !inmap |-> pslverr)
    else $error("no error on unmapped access");
  mapped_ok_a: assert property (acc && inmap && paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 |-> !pslverr)
    else $error("error on mapped access");
  read_upper_zero_a: assert property (rd |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  status_low_a: assert property (rd && paddr == 12'h0F8 |-> prdata[2:0] == {dis, 2'b00})
    else $error("status low bits wrong");
  disable_oe_a: assert property (dis |-> !compare_one_oe && !compare_two_oe)
    else $error("compare pin enabled while disabled");
  counter_reload_a: assert property (rd && cw && paddr inside {12'h104, 12'h108} |-> prdata[7:0] == 8'hFC)
    else $error("counter not reloaded");
  irq_masked_a: assert property (ie == 3'h0 |-> !timer_irq)
    else $error("interrupt with all enables off");
endmodule
bind ett_timer ett_timer_sva ett_timer_sva_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .capture_one_pin, .capture_two_pin, .compare_one_pin, .compare_one_oe, .compare_two_pin,
  .compare_two_oe, .timer_irq);
`default_nettype wire

// ==== dv/ett_timer_tb_top.sv ====
// self-checking bench for the capture/compare timer
`timescale 1ns/1ns
`default_nettype none
module ett_timer_tb_top import ett_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic capture_one_pin, capture_two_pin, compare_one_pin, compare_one_oe, compare_two_pin, compare_two_oe;
  logic timer_irq;
  logic [7:0] q, v, exp_st, c1, c2;
  logic [7:0] clr_idx [5] = '{IDX_CAP_ONE, IDX_CMP_ONE, IDX_COUNTER, IDX_CAP_TWO, IDX_CMP_TWO};
  int fail_count, checked, k, n;
  integer seed;
  ett_timer #(.SLOW_DIVIDE(16)) ett_timer_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .capture_one_pin, .capture_two_pin, .compare_one_pin, .compare_one_oe, .compare_two_pin,
    .compare_two_oe, .timer_irq);
  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction
  function automatic logic [7:0] cnt_exp(input int cyc);
    return 8'(CNT_RST + cyc / 2);
  endfunction
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("FAIL t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] x);
    xfer(ad(idx), 1'b0, 8'h00);
    chk(q, x);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(ad(idx), 1'b1, d);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (3000) @(posedge pclk);
    fail_count++;
    finish_test;
  end
  initial begin
    seed = 19;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    capture_one_pin = 1'b0;
    capture_two_pin = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(IDX_STATUS, 8'hFF);
    rdc(IDX_STATUS, 8'h04);
    rdc(IDX_COUNTER, CNT_RST);
    rdc(IDX_CTL_TWO, CTL_RST);
    rdc(IDX_CTL_ONE, CTL_RST);
    rdc(IDX_CMP_ONE, CMP_RST);
    rdc(IDX_CMP_TWO, CMP_RST);
    wr(IDX_COUNTER, 8'($random(seed)));
    rdc(IDX_COUNTER, CNT_RST);
    wr(IDX_SHADOW, 8'($random(seed)));
    rdc(IDX_SHADOW, CNT_RST);
    c1 = 8'($random(seed)) & 8'h3F;
    c2 = 8'($random(seed)) & 8'h3F;
    v = 8'($random(seed));
    wr(IDX_CTL_ONE, v);
    rdc(IDX_CTL_ONE, v);
    wr(IDX_CTL_ONE, 8'hE2);
    wr(IDX_CTL_TWO, 8'hC7);
    rdc(IDX_CTL_TWO, 8'hC6);
    wr(IDX_CMP_ONE, c1);
    rdc(IDX_CMP_ONE, c1);
    wr(IDX_CMP_TWO, c2);
    rdc(IDX_CMP_TWO, c2);
    chk({6'h0, compare_one_oe, compare_two_oe}, 8'h00);
    xfer(12'h200, 1'b0, 8'h00);
    chk(q, 8'h00);
    chk({7'h0, err}, 8'h01);
    $display("register access done");
    wr(IDX_STATUS, 8'h00);
    chk({6'h0, compare_one_oe, compare_two_oe}, 8'h03);
    repeat (200) @(posedge pclk);
    wr(IDX_STATUS, 8'h04);
    xfer(ad(IDX_COUNTER), 1'b0, 8'h00);
    v = q;
    chk({7'h0, 8'(v - cnt_exp(202) + 8'h03) <= 8'h06}, 8'h01);
    repeat (20) @(posedge pclk);
    rdc(IDX_COUNTER, v);
    rdc(IDX_STATUS, 8'h6C);
    chk({7'h0, timer_irq}, 8'h01);
    $display("counting done");
    capture_one_pin <= 1'b1;
    capture_two_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    capture_one_pin <= 1'b0;
    capture_two_pin <= 1'b0;
    @(posedge pclk);
    rdc(IDX_CAP_ONE, v);
    rdc(IDX_CAP_TWO, v);
    rdc(IDX_STATUS, 8'hFC);
    rdc(IDX_SHADOW, v);
    wr(IDX_SHADOW, 8'($random(seed)));
    rdc(IDX_SHADOW, CNT_RST);
    rdc(IDX_STATUS, 8'hFC);
    exp_st = 8'hFC;
    for (k = 0; k < 5; k++) begin
      rdc(IDX_STATUS, exp_st);
      xfer(ad(clr_idx[k]), k == 2, 8'($random(seed)));
      exp_st = exp_st & ~(8'h80 >> k);
    end
    rdc(IDX_STATUS, 8'h04);
    chk({7'h0, timer_irq}, 8'h00);
    $display("flag clearing done");
    // pulse-width mode on the divide-by-eight tick, measured on the compare one pin
    c1 = 8'h01 + (8'($random(seed)) & 8'h03);
    c2 = 8'h07;
    wr(IDX_CTL_ONE, 8'h04);
    wr(IDX_CMP_ONE, c1);
    wr(IDX_CMP_TWO, c2);
    wr(IDX_CTL_TWO, 8'h98);
    wr(IDX_STATUS, 8'h00);
    n = 0;
    while (compare_one_pin !== 1'b1) begin
      @(negedge pclk);
    end
    while (compare_one_pin === 1'b1) begin
      @(negedge pclk);
      n++;
    end
    chk(8'(n), 8'(DIV_EIGHT * c1 + 1));
    while (compare_one_pin !== 1'b1) begin
      @(negedge pclk);
      n++;
    end
    chk(8'(n), 8'(DIV_EIGHT * (c2 + 8'h01)));
    @(posedge pclk);
    wr(IDX_STATUS, 8'h04);
    rdc(IDX_STATUS, 8'hA4);
    chk({7'h0, timer_irq}, 8'h00);
    // forced level on pin two is held while disabled, shown once running
    wr(IDX_CTL_ONE, 8'h14);
    @(negedge pclk);
    chk({7'h0, compare_two_pin}, 8'h00);
    @(posedge pclk);
    wr(IDX_STATUS, 8'h00);
    @(negedge pclk);
    chk({7'h0, compare_two_pin}, 8'h01);
    @(posedge pclk);
    $display("pwm and compare pins done");
    finish_test;
  end
endmodule
`default_nettype wire
